// ==== ubrg_pkg.sv ====
// Constants shared by the baud rate generator block.
// Assumes one core clock; register offsets are byte addresses on a plain port.
package ubrg_pkg;
  // Register offsets
  localparam logic [2:0] ADDR_TX_CTRL   = 3'h0;
  localparam logic [2:0] ADDR_RX_CTRL   = 3'h1;
  localparam logic [2:0] ADDR_BAUD_CTRL = 3'h2;
  localparam logic [2:0] ADDR_DIV_LO    = 3'h3;
  localparam logic [2:0] ADDR_DIV_HI    = 3'h4;
  localparam logic [2:0] ADDR_IRQ_STAT  = 3'h5;
  localparam logic [2:0] ADDR_IRQ_MASK  = 3'h6;

  // tx_status_control fields
  localparam int TX_CLK_MASTER_BIT = 7;
  localparam int TX_SYNC_BIT       = 4;
  localparam int TX_HIGH_SPEED_BIT = 2;
  localparam int TX_EMPTY_BIT      = 1;
  localparam logic [7:0] TX_WR_MASK = 8'hfd;
  localparam logic [7:0] TX_RESET   = 8'h02;

  // rx_status_control fields
  localparam int RX_CONT_EN_BIT  = 4;
  localparam int RX_FRAME_BIT    = 2;
  localparam int RX_OVERRUN_BIT  = 1;
  localparam int RX_NINTH_BIT    = 0;
  localparam logic [7:0] RX_WR_MASK = 8'hf8;
  localparam logic [7:0] RX_RESET   = 8'h00;

  // baud_control fields
  localparam int BC_AUTO_OVF_BIT = 7;
  localparam int BC_RX_IDLE_BIT  = 6;
  localparam int BC_WIDE_BIT     = 3;
  localparam int BC_WAKE_BIT     = 1;
  localparam int BC_AUTO_EN_BIT  = 0;
  localparam logic [7:0] BC_WR_MASK = 8'h9b;
  localparam logic [7:0] BC_RESET   = 8'h40;

  localparam logic [7:0] DIV_RESET = 8'h00;

  // Interrupt status bits
  localparam int IRQ_TICK_BIT    = 0;
  localparam int IRQ_OVERRUN_BIT = 1;
  localparam int IRQ_AUTO_OVF_BIT = 2;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Fixed prescale after the timer, in timer wraps per bit
  localparam logic [6:0] PRE_ASYNC_LOW  = 7'h40;
  localparam logic [6:0] PRE_ASYNC_MID  = 7'h10;
  localparam logic [6:0] PRE_SYNC       = 7'h04;
endpackage

// ==== ubrg_timer.sv ====
// Free-running down counter that wraps at zero and reloads the divisor.
// Assumes the clear pulse comes from the register block on the same clock.
`timescale 1ns/1ns
module ubrg_timer (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clr,
  input  wire logic [15:0] i_div,
  output logic             o_tick,
  output logic [15:0]      o_count
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        tick_q;
  logic        tick_d;

  always_comb begin
    cnt_d  = cnt_q - 16'h0001;
    tick_d = 1'b0;
    if (i_clr) begin
      cnt_d = i_div;
    end else if (cnt_q == 16'h0000) begin
      cnt_d  = i_div;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick  = tick_q;
  assign o_count = cnt_q;

  a_timer_wrap : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_clr && cnt_q == 16'h0000) |=> (tick_q && cnt_q == $past(i_div)))
    else $error("timer did not tick and reload at zero");

  a_timer_step : assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (!i_clr && cnt_q != 16'h0000) |=> (!tick_q && cnt_q == $past(cnt_q) - 16'h0001))
    else $error("timer did not count down by one");
endmodule

// ==== ubrg_prescale.sv ====
// Fixed prescaler: one bit tick every i_div timer wraps.
// Assumes i_div is 4, 16 or 64 and changes only with a clear.
`timescale 1ns/1ns
module ubrg_prescale (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_clr,
  input  wire logic       i_tick,
  input  wire logic [6:0] i_div,
  output logic            o_tick
);
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic       tick_q;
  logic       tick_d;

  always_comb begin
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (i_clr) begin
      cnt_d = 7'h00;
    end else if (i_tick) begin
      if (cnt_q >= i_div - 7'h01) begin
        cnt_d  = 7'h00;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 7'h01;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q  <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign o_tick = tick_q;
endmodule

// ==== ubrg_top.sv ====
// Baud rate generator with its control registers and interrupt.
// Assumes a one-cycle strobe register port and a receiver on the same clock.
`timescale 1ns/1ns
module ubrg_top (
  input  wire logic       I_CORE_CLK,
  input  wire logic       I_RST_N,
  input  wire logic [2:0] I_ADDR,
  input  wire logic [7:0] I_WDATA,
  input  wire logic       I_WR,
  input  wire logic       I_RD,
  input  wire logic       I_EXT_CLK,
  input  wire logic       I_RX_LOST,
  input  wire logic       I_AUTO_OVF,
  input  wire logic       I_RX_IDLE,
  input  wire logic       I_FRAME_ERR,
  input  wire logic       I_RX_NINTH,
  output logic [7:0]      O_RDATA,
  output logic            O_BIT_TICK,
  output logic            O_IRQ,
  output logic            O_WAKE_EN,
  output logic            O_AUTO_RATE_EN
);
  logic [7:0] tx_ctrl_q, tx_ctrl_d;
  logic [7:0] rx_ctrl_q, rx_ctrl_d;
  logic [7:0] baud_ctrl_q, baud_ctrl_d;
  logic [7:0] div_lo_q, div_lo_d;
  logic [7:0] div_hi_q, div_hi_d;
  logic [2:0] irq_stat_q, irq_stat_d;
  logic [2:0] irq_mask_q, irq_mask_d;
  logic       div_clr_q, div_clr_d;
  logic [7:0] rdata_q, rdata_d;
  logic       irq_q, irq_d;
  logic       bit_tick_q, bit_tick_d;
  logic       wake_q, wake_d;
  logic       auto_q, auto_d;
  logic       ext_s1_q, ext_s2_q, ext_s3_q;
  logic       ext_rise;
  logic       sync_mode;
  logic       clk_master;
  logic       wide_sel;
  logic       high_speed;
  logic       cont_rx_en;
  logic [15:0] divisor_n;
  logic [6:0]  pre_div;
  logic        timer_tick;
  logic        pre_tick;
  logic [15:0] timer_count;
  logic        wr_tx, wr_rx, wr_bc, wr_lo, wr_hi, wr_mask, rd_stat;
  logic        overrun_set;

  assign sync_mode  = tx_ctrl_q[ubrg_pkg::TX_SYNC_BIT];
  assign clk_master = tx_ctrl_q[ubrg_pkg::TX_CLK_MASTER_BIT];
  assign high_speed = tx_ctrl_q[ubrg_pkg::TX_HIGH_SPEED_BIT];
  assign wide_sel   = baud_ctrl_q[ubrg_pkg::BC_WIDE_BIT];
  assign cont_rx_en = rx_ctrl_q[ubrg_pkg::RX_CONT_EN_BIT];

  assign wr_tx   = I_WR && (I_ADDR == ubrg_pkg::ADDR_TX_CTRL);
  assign wr_rx   = I_WR && (I_ADDR == ubrg_pkg::ADDR_RX_CTRL);
  assign wr_bc   = I_WR && (I_ADDR == ubrg_pkg::ADDR_BAUD_CTRL);
  assign wr_lo   = I_WR && (I_ADDR == ubrg_pkg::ADDR_DIV_LO);
  assign wr_hi   = I_WR && (I_ADDR == ubrg_pkg::ADDR_DIV_HI);
  assign wr_mask = I_WR && (I_ADDR == ubrg_pkg::ADDR_IRQ_MASK);
  assign rd_stat = I_RD && (I_ADDR == ubrg_pkg::ADDR_IRQ_STAT);

  // High byte drops out while the narrow divider is selected
  assign divisor_n = wide_sel ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};

  // Fixed prescale per mode; high speed only counts when asynchronous
  always_comb begin
    if (sync_mode) begin
      pre_div = ubrg_pkg::PRE_SYNC;
    end else if (!wide_sel && !high_speed) begin
      pre_div = ubrg_pkg::PRE_ASYNC_LOW;
    end else if (wide_sel && high_speed) begin
      pre_div = ubrg_pkg::PRE_SYNC;
    end else begin
      pre_div = ubrg_pkg::PRE_ASYNC_MID;
    end
  end

  ubrg_timer u_timer (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_clr   (div_clr_q),
    .i_div   (divisor_n),
    .o_tick  (timer_tick),
    .o_count (timer_count)
  );

  ubrg_prescale u_prescale (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (I_RST_N),
    .i_clr   (div_clr_q),
    .i_tick  (timer_tick),
    .i_div   (pre_div),
    .o_tick  (pre_tick)
  );

  // External clock pin synchroniser; edge taken past the second stage
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
      ext_s3_q <= 1'b0;
    end else begin
      ext_s1_q <= I_EXT_CLK;
      ext_s2_q <= ext_s1_q;
      ext_s3_q <= ext_s2_q;
    end
  end

  assign ext_rise    = ext_s2_q && !ext_s3_q;
  assign overrun_set = I_RX_LOST && cont_rx_en;

  // Register writes and hardware-owned bits
  always_comb begin
    tx_ctrl_d   = tx_ctrl_q;
    rx_ctrl_d   = rx_ctrl_q;
    baud_ctrl_d = baud_ctrl_q;
    div_lo_d    = div_lo_q;
    div_hi_d    = div_hi_q;
    irq_mask_d  = irq_mask_q;
    if (wr_tx) begin
      tx_ctrl_d = (I_WDATA & ubrg_pkg::TX_WR_MASK) | ubrg_pkg::TX_RESET;
    end
    if (wr_rx) begin
      rx_ctrl_d = (I_WDATA & ubrg_pkg::RX_WR_MASK) | (rx_ctrl_q & ~ubrg_pkg::RX_WR_MASK);
      if (!I_WDATA[ubrg_pkg::RX_CONT_EN_BIT]) begin
        rx_ctrl_d[ubrg_pkg::RX_OVERRUN_BIT] = 1'b0;
      end
    end
    if (wr_bc) begin
      baud_ctrl_d = (I_WDATA & ubrg_pkg::BC_WR_MASK) | (baud_ctrl_q & ~ubrg_pkg::BC_WR_MASK);
    end
    if (wr_lo) begin
      div_lo_d = I_WDATA;
    end
    if (wr_hi) begin
      div_hi_d = I_WDATA;
    end
    if (wr_mask) begin
      irq_mask_d = I_WDATA[2:0];
    end
    // Loss while receiving wins over a clear in the same cycle
    if (overrun_set) begin
      rx_ctrl_d[ubrg_pkg::RX_OVERRUN_BIT] = 1'b1;
    end
    if (I_AUTO_OVF) begin
      baud_ctrl_d[ubrg_pkg::BC_AUTO_OVF_BIT] = 1'b1;
    end
    rx_ctrl_d[ubrg_pkg::RX_FRAME_BIT]   = I_FRAME_ERR;
    rx_ctrl_d[ubrg_pkg::RX_NINTH_BIT]   = I_RX_NINTH;
    baud_ctrl_d[ubrg_pkg::BC_RX_IDLE_BIT] = I_RX_IDLE;
    div_clr_d = wr_lo || wr_hi;
  end

  // Interrupt status, read to clear, set wins
  always_comb begin
    irq_stat_d = rd_stat ? 3'h0 : irq_stat_q;
    if (bit_tick_q) begin
      irq_stat_d[ubrg_pkg::IRQ_TICK_BIT] = 1'b1;
    end
    if (overrun_set) begin
      irq_stat_d[ubrg_pkg::IRQ_OVERRUN_BIT] = 1'b1;
    end
    if (I_AUTO_OVF) begin
      irq_stat_d[ubrg_pkg::IRQ_AUTO_OVF_BIT] = 1'b1;
    end
    irq_d = |(irq_stat_d & irq_mask_d);
  end

  // Outputs and read data
  always_comb begin
    rdata_d = 8'h00;
    if (I_RD) begin
      if (I_ADDR == ubrg_pkg::ADDR_TX_CTRL) begin
        rdata_d = tx_ctrl_q;
      end else if (I_ADDR == ubrg_pkg::ADDR_RX_CTRL) begin
        rdata_d = rx_ctrl_q;
      end else if (I_ADDR == ubrg_pkg::ADDR_BAUD_CTRL) begin
        rdata_d = baud_ctrl_q;
      end else if (I_ADDR == ubrg_pkg::ADDR_DIV_LO) begin
        rdata_d = div_lo_q;
      end else if (I_ADDR == ubrg_pkg::ADDR_DIV_HI) begin
        rdata_d = div_hi_q;
      end else if (I_ADDR == ubrg_pkg::ADDR_IRQ_STAT) begin
        rdata_d = {5'h00, irq_stat_q};
      end else if (I_ADDR == ubrg_pkg::ADDR_IRQ_MASK) begin
        rdata_d = {5'h00, irq_mask_q};
      end
    end
    // Slave in sync mode: divisor rate is unused, pin edges pace bits
    if (sync_mode && !clk_master) begin
      bit_tick_d = ext_rise;
    end else begin
      bit_tick_d = pre_tick;
    end
    wake_d = baud_ctrl_q[ubrg_pkg::BC_WAKE_BIT] && !sync_mode;
    auto_d = baud_ctrl_q[ubrg_pkg::BC_AUTO_EN_BIT] && !sync_mode;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      tx_ctrl_q   <= ubrg_pkg::TX_RESET;
      rx_ctrl_q   <= ubrg_pkg::RX_RESET;
      baud_ctrl_q <= ubrg_pkg::BC_RESET;
      div_lo_q    <= ubrg_pkg::DIV_RESET;
      div_hi_q    <= ubrg_pkg::DIV_RESET;
      irq_stat_q  <= ubrg_pkg::IRQ_RESET;
      irq_mask_q  <= ubrg_pkg::IRQ_RESET;
      div_clr_q   <= 1'b0;
      rdata_q     <= 8'h00;
      irq_q       <= 1'b0;
      bit_tick_q  <= 1'b0;
      wake_q      <= 1'b0;
      auto_q      <= 1'b0;
    end else begin
      tx_ctrl_q   <= tx_ctrl_d;
      rx_ctrl_q   <= rx_ctrl_d;
      baud_ctrl_q <= baud_ctrl_d;
      div_lo_q    <= div_lo_d;
      div_hi_q    <= div_hi_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
      div_clr_q   <= div_clr_d;
      rdata_q     <= rdata_d;
      irq_q       <= irq_d;
      bit_tick_q  <= bit_tick_d;
      wake_q      <= wake_d;
      auto_q      <= auto_d;
    end
  end

  assign O_RDATA        = rdata_q;
  assign O_BIT_TICK     = bit_tick_q;
  assign O_IRQ          = irq_q;
  assign O_WAKE_EN      = wake_q;
  assign O_AUTO_RATE_EN = auto_q;

  a_narrow_high_ignored : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !wide_sel |-> (divisor_n[15:8] == 8'h00 && divisor_n[7:0] == div_lo_q))
    else $error("high divisor byte used in narrow mode");

  a_wide_pair_used : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    wide_sel |-> divisor_n == {div_hi_q, div_lo_q})
    else $error("wide divisor does not pair high over low");

  a_master_tick_src : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    !(sync_mode && !clk_master) |=> (O_BIT_TICK == $past(pre_tick)))
    else $error("internal bit tick not from the divisor timer");

  a_async_low_scale : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (!sync_mode && !wide_sel && !high_speed) |-> pre_div == 7'h40)
    else $error("async low speed prescale is not 64");

  a_async_mid_scale : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (!sync_mode && (wide_sel ^ high_speed)) |-> pre_div == 7'h10)
    else $error("async mid prescale is not 16");

  a_sync_ignores_high : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    sync_mode |-> pre_div == 7'h04)
    else $error("sync prescale depends on high speed");

  a_slave_ext_only : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (sync_mode && !clk_master && !wr_tx) |=> (O_BIT_TICK == $past(ext_rise)))
    else $error("slave bit tick not from external clock");

  a_div_write_restart : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (wr_lo || wr_hi) && !wr_bc |-> ##2 (timer_count == $past(divisor_n)))
    else $error("divisor write did not restart the timer");

  a_sync_enables_off : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    sync_mode |=> (!O_WAKE_EN && !O_AUTO_RATE_EN))
    else $error("wake or auto-rate enable active in sync mode");

  a_overrun_set : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    overrun_set |=> rx_ctrl_q[ubrg_pkg::RX_OVERRUN_BIT])
    else $error("overrun not flagged on lost character");

  a_overrun_hold : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (rx_ctrl_q[ubrg_pkg::RX_OVERRUN_BIT] && cont_rx_en && !wr_rx) |=>
      rx_ctrl_q[ubrg_pkg::RX_OVERRUN_BIT])
    else $error("overrun cleared while receive stays enabled");

  a_irq_follows : assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    O_IRQ == |(irq_stat_q & irq_mask_q))
    else $error("interrupt output disagrees with status and mask");
endmodule

// ==== ubrg_partner.sv ====
// Far-side serial partner: external bit clock and receiver events.
// Assumes the core clock paces it; the clock pin idles low between frames.
`timescale 1ns/1ns
module ubrg_partner (
  input  wire logic i_clk,
  output logic      o_ext_clk,
  output logic      o_rx_lost,
  output logic      o_auto_ovf,
  output logic      o_rx_idle,
  output logic      o_frame_err,
  output logic      o_rx_ninth
);
  initial begin
    o_ext_clk = 1'b0;
    o_rx_lost = 1'b0;
    o_auto_ovf = 1'b0;
    o_rx_idle = 1'b1;
    o_frame_err = 1'b0;
    o_rx_ninth = 1'b0;
  end

  // Clock toggles only inside a frame, slow against the core clock
  task automatic send_clocks(input int n);
    repeat (n) begin
      @(posedge i_clk) o_ext_clk <= 1'b1;
      repeat (5) @(posedge i_clk);
      o_ext_clk <= 1'b0;
      repeat (5) @(posedge i_clk);
    end
  endtask

  task automatic pulse_lost();
    @(posedge i_clk) o_rx_lost <= 1'b1;
    @(posedge i_clk) o_rx_lost <= 1'b0;
  endtask

  task automatic pulse_auto();
    @(posedge i_clk) o_auto_ovf <= 1'b1;
    @(posedge i_clk) o_auto_ovf <= 1'b0;
  endtask

  task automatic set_levels(input logic idle, input logic framing_error_flag, input logic ninth);
    @(posedge i_clk);
    o_rx_idle <= idle;
    o_frame_err <= framing_error_flag;
    o_rx_ninth <= ninth;
  endtask
endmodule

// ==== testbench.sv ====
// Self-checking bench for the baud rate generator and its registers.
// Assumes the register port of ubrg_top and a partner on the far side.
`timescale 1ns/1ns
module testbench;
  logic        I_CORE_CLK = 1'b0;
  logic        I_RST_N = 1'b0;
  logic [2:0]  I_ADDR = 3'h0;
  logic [7:0]  I_WDATA = 8'h00;
  logic        I_WR = 1'b0;
  logic        I_RD = 1'b0;
  logic        ext_clk, rx_lost, auto_ovf, rx_idle, frame_err, rx_ninth;
  logic [7:0]  O_RDATA;
  logic        O_BIT_TICK, O_IRQ, O_WAKE_EN, O_AUTO_RATE_EN;
  int          failures = 0;
  int          check_count = 0;
  int          ticks = 0;
  int          t0;
  logic [15:0] gap;
  logic [7:0]  rst_val [8] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // tx, baud, div hi, div lo, expected cycles between ticks
  logic [47:0] cfgs [8] = '{48'h00000002_00c0, 48'h04000002_0030, 48'h00080101_1020,
                            48'h00000101_0080, 48'h04080001_0008, 48'h94000003_0010,
                            48'h90000003_0010, 48'h90080100_0404};

  always #4 I_CORE_CLK = ~I_CORE_CLK;
  always @(posedge I_CORE_CLK) if (O_BIT_TICK === 1'b1) ticks <= ticks + 1;

  ubrg_top dut (.I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
    .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_EXT_CLK(ext_clk),
    .I_RX_LOST(rx_lost), .I_AUTO_OVF(auto_ovf), .I_RX_IDLE(rx_idle),
    .I_FRAME_ERR(frame_err), .I_RX_NINTH(rx_ninth), .O_RDATA(O_RDATA),
    .O_BIT_TICK(O_BIT_TICK), .O_IRQ(O_IRQ), .O_WAKE_EN(O_WAKE_EN),
    .O_AUTO_RATE_EN(O_AUTO_RATE_EN));

  ubrg_partner partner (.i_clk(I_CORE_CLK), .o_ext_clk(ext_clk), .o_rx_lost(rx_lost),
    .o_auto_ovf(auto_ovf), .o_rx_idle(rx_idle), .o_frame_err(frame_err),
    .o_rx_ninth(rx_ninth));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge I_CORE_CLK);
    I_WR <= 1'b1;
    I_ADDR <= a;
    I_WDATA <= d;
    @(posedge I_CORE_CLK);
    I_WR <= 1'b0;
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    @(posedge I_CORE_CLK);
    I_RD <= 1'b1;
    I_ADDR <= a;
    @(posedge I_CORE_CLK);
    I_RD <= 1'b0;
    #1 chk({8'h00, O_RDATA}, {8'h00, e});
  endtask

  // O_WAKE_EN, O_AUTO_RATE_EN and O_IRQ are looked at only after this, never in the edge that launches them
  task automatic settle();
    repeat (2) @(posedge I_CORE_CLK);
    #1;
  endtask

  // Bounded wait so a dead generator cannot hang the run
  task automatic wait_tick(output logic [15:0] c);
    c = 16'h0000;
    do begin
      @(posedge I_CORE_CLK);
      #1 c = c + 16'h0001;
    end while (O_BIT_TICK !== 1'b1 && c < 16'd9000);
  endtask

  task automatic cfg(input logic [7:0] tx, input logic [7:0] bc, input logic [7:0] hi,
                     input logic [7:0] lo);
    wr(ubrg_pkg::ADDR_TX_CTRL, tx);
    wr(ubrg_pkg::ADDR_BAUD_CTRL, bc);
    wr(ubrg_pkg::ADDR_DIV_HI, hi);
    wr(ubrg_pkg::ADDR_DIV_LO, lo);
  endtask

  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end

  initial begin
    repeat (16) @(posedge I_CORE_CLK);
    I_RST_N <= 1'b1;
    repeat (2) @(posedge I_CORE_CLK);
    for (int i = 0; i < 8; i++)
      rdc(3'(i), rst_val[i]);
    @(posedge I_CORE_CLK);
    #1 chk({8'h00, O_RDATA}, 16'h0000);
    wr(3'h7, 8'hff);
    rdc(3'h7, 8'h00);
    wr(ubrg_pkg::ADDR_TX_CTRL, 8'hfd);
    rdc(ubrg_pkg::ADDR_TX_CTRL, 8'hff);
    wr(ubrg_pkg::ADDR_RX_CTRL, 8'hff);
    rdc(ubrg_pkg::ADDR_RX_CTRL, 8'hf8);
    wr(ubrg_pkg::ADDR_BAUD_CTRL, 8'h1b);
    rdc(ubrg_pkg::ADDR_BAUD_CTRL, 8'h5b);
    wr(ubrg_pkg::ADDR_RX_CTRL, 8'h00);
    // Eight fixed settings swept, each checked for its cycles between ticks
    for (int i = 0; i < 8; i++) begin
      cfg(cfgs[i][47:40], cfgs[i][39:32], cfgs[i][31:24], cfgs[i][23:16]);
      wait_tick(gap);
      wait_tick(gap);
      chk(gap, cfgs[i][15:0]);
    end
    cfg(8'h00, 8'h03, 8'h00, 8'h00);
    settle();
    chk({15'h0000, O_WAKE_EN & O_AUTO_RATE_EN}, 16'h0001);
    wr(ubrg_pkg::ADDR_TX_CTRL, 8'h90);
    settle();
    chk({15'h0000, O_WAKE_EN | O_AUTO_RATE_EN}, 16'h0000);
    cfg(8'h00, 8'h00, 8'h00, 8'h02);
    for (int k = 0; k < 2; k++) begin
      wait_tick(gap);
      repeat (100) @(posedge I_CORE_CLK);
      wr(k == 0 ? ubrg_pkg::ADDR_DIV_LO : ubrg_pkg::ADDR_DIV_HI, k == 0 ? 8'h02 : 8'h00);
      wait_tick(gap);
      chk({15'h0000, gap > 16'd180 && gap < 16'd200}, 16'h0001);
    end
    wr(ubrg_pkg::ADDR_TX_CTRL, 8'h10);
    repeat (10) @(posedge I_CORE_CLK);
    t0 = ticks;
    partner.send_clocks(5);
    repeat (10) @(posedge I_CORE_CLK);
    chk(16'(ticks - t0), 16'h0005);
    repeat (300) @(posedge I_CORE_CLK);
    chk(16'(ticks - t0), 16'h0005);
    partner.set_levels(1'b0, 1'b1, 1'b1);
    repeat (2) @(posedge I_CORE_CLK);
    rdc(ubrg_pkg::ADDR_RX_CTRL, 8'h05);
    rdc(ubrg_pkg::ADDR_BAUD_CTRL, 8'h00);
    partner.set_levels(1'b1, 1'b0, 1'b0);
    rdc(ubrg_pkg::ADDR_IRQ_STAT, 8'h01);
    wr(ubrg_pkg::ADDR_IRQ_MASK, 8'h04);
    partner.pulse_auto();
    settle();
    chk({15'h0000, O_IRQ}, 16'h0001);
    rdc(ubrg_pkg::ADDR_IRQ_STAT, 8'h04);
    settle();
    chk({15'h0000, O_IRQ}, 16'h0000);
    rdc(ubrg_pkg::ADDR_BAUD_CTRL, 8'hc0);
    wr(ubrg_pkg::ADDR_BAUD_CTRL, 8'h00);
    rdc(ubrg_pkg::ADDR_BAUD_CTRL, 8'h40);
    wr(ubrg_pkg::ADDR_RX_CTRL, 8'h10);
    partner.pulse_lost();
    rdc(ubrg_pkg::ADDR_RX_CTRL, 8'h12);
    settle();
    chk({15'h0000, O_IRQ}, 16'h0000);
    wr(ubrg_pkg::ADDR_RX_CTRL, 8'h10);
    rdc(ubrg_pkg::ADDR_RX_CTRL, 8'h12);
    wr(ubrg_pkg::ADDR_IRQ_MASK, 8'h02);
    settle();
    chk({15'h0000, O_IRQ}, 16'h0001);
    rdc(ubrg_pkg::ADDR_IRQ_STAT, 8'h02);
    settle();
    chk({15'h0000, O_IRQ}, 16'h0000);
    wr(ubrg_pkg::ADDR_RX_CTRL, 8'h00);
    rdc(ubrg_pkg::ADDR_RX_CTRL, 8'h00);
    partner.pulse_lost();
    rdc(ubrg_pkg::ADDR_RX_CTRL, 8'h00);
    tally_and_finish();
  end
endmodule
